// [rtl/iap_pkg.sv]
// Purpose: Shared constants and types for the flash page programmer
// Assumes: 40 MHz core clock, 32-bit APB, one instruction cycle = 4 clocks
// Notes:   Register offsets are byte addresses, one aligned word each
package iap_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int PROG_TIME_NS   = 2200000;  // Typical erase or program time
  localparam int PROG_CYC       = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int READ_INSTR     = 3;        // Read time in instruction cycles
  localparam int CLK_PER_INSTR  = 4;
  localparam int READ_CYC       = READ_INSTR * CLK_PER_INSTR;
  // Geometry
  localparam int BUF_WORDS      = 32;
  localparam int OFS_BITS       = 5;
  localparam int PAGE_BITS      = 8;
  localparam int ADDR_BITS      = 13;
  localparam int FLASH_WORDS    = 8192;
  localparam logic [15:0] ERASED_WORD = 16'h0000;
  // Register offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_CLEAR = 8'h04;
  localparam logic [7:0] OFF_ADRL  = 8'h08;
  localparam logic [7:0] OFF_ADRH  = 8'h0c;
  localparam logic [7:0] OFF_WRDL  = 8'h10;
  localparam logic [7:0] OFF_WRDH  = 8'h14;
  // Control register fields
  localparam int BIT_RD_TRIG  = 0;
  localparam int BIT_RD_EN    = 1;
  localparam int BIT_PROG     = 2;
  localparam int OPSEL_LSB    = 4;
  localparam int BIT_UNLOCKED = 7;
  localparam int BIT_CLEAR    = 0;
  localparam logic [2:0] OP_WRITE = 3'h0;
  localparam logic [2:0] OP_ERASE = 3'h1;
  localparam logic [2:0] OP_READ  = 3'h3;
  localparam logic [2:0] OPSEL_RST = 3'h0;
  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_READ} seq_state_t;
endpackage

// [rtl/flash_iap_page_programmer.sv]
// Purpose: In-application flash programmer with a 32-word page buffer
// Assumes: Unlock procedure lives elsewhere and pulses unlock_grant_i
// Notes:   Flash array is modelled in this module; programming ORs bits in
`timescale 1ns/100ps
module flash_iap_page_programmer
  import iap_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire apb_req_t    apb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // System side
  input  wire logic        unlock_grant_i,
  output logic             cpu_stall_o
);

  // Counter must hold the longer of the two busy times, even for a short sim count
  localparam int CW = $clog2((PROG_CYCLES > READ_CYC ? PROG_CYCLES : READ_CYC) + 1);
  localparam int RD_WAIT = READ_CYC + 1;

  // Full flash address from page and word offset
  function automatic logic [ADDR_BITS-1:0] word_addr(input logic [PAGE_BITS-1:0] pg,
                                                      input int i);
    word_addr = {pg, OFS_BITS'(i)};
  endfunction

  logic [15:0]          flash_mem [FLASH_WORDS];
  logic [15:0]          buf_mem   [BUF_WORDS];
  seq_state_t           state_reg;
  seq_state_t           state_next;
  logic [CW-1:0]        cnt_reg;
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic [31:0]          prdata_reg;
  logic                 stall_reg;
  logic [2:0]           opsel_reg;
  logic                 rden_reg;
  logic                 rdtrig_reg;
  logic                 progtrig_reg;
  logic                 unlocked_reg;
  logic                 erase_reg;
  logic                 clr_reg;
  logic [7:0]           adrl_reg;
  logic [4:0]           adrh_reg;
  logic [7:0]           wrdl_reg;
  logic [7:0]           wrdh_reg;
  logic [OFS_BITS-1:0]  idx_reg;

  // Bus decode
  wire        acc      = apb_i.psel & apb_i.penable & pready_reg;
  wire        setup    = apb_i.psel & apb_i.penable & ~pready_reg;
  wire        wr       = acc & apb_i.pwrite;
  wire [7:0]  wd       = apb_i.pwdata[7:0];
  wire        hit_ctrl = apb_i.paddr == OFF_CTRL;
  wire        hit_clr  = apb_i.paddr == OFF_CLEAR;
  wire        hit_adrl = apb_i.paddr == OFF_ADRL;
  wire        hit_adrh = apb_i.paddr == OFF_ADRH;
  wire        hit_wrdl = apb_i.paddr == OFF_WRDL;
  wire        hit_wrdh = apb_i.paddr == OFF_WRDH;
  wire        hit      = hit_ctrl | hit_clr | hit_adrl | hit_adrh | hit_wrdl | hit_wrdh;
  wire        wr_ctrl  = wr & hit_ctrl;
  wire        wr_adrl  = wr & hit_adrl;
  wire        wr_wrdh  = wr & hit_wrdh;
  wire [2:0]  op_new   = wd[OPSEL_LSB +: 3];
  wire        idle     = state_reg == ST_IDLE;

  // Operation starts; write trigger wins over read if both are set
  wire start_prog = wr_ctrl & wd[BIT_PROG] & idle & unlocked_reg
                    & (op_new == OP_WRITE | op_new == OP_ERASE);
  wire start_read = wr_ctrl & wd[BIT_RD_TRIG] & wd[BIT_RD_EN] & idle
                    & (op_new == OP_READ) & ~start_prog;
  wire prog_done  = state_reg == ST_PROG && cnt_reg == '0;
  wire read_done  = state_reg == ST_READ && cnt_reg == '0;
  wire [PAGE_BITS-1:0] page = {adrh_reg, adrl_reg[7:5]};
  wire [ADDR_BITS-1:0] full_addr = {adrh_reg, adrl_reg};

  // Register read mux
  wire [31:0] rd_val =
      hit_ctrl ? {24'h0, unlocked_reg, opsel_reg, 1'b0, progtrig_reg, rden_reg, rdtrig_reg} :
      hit_clr  ? {31'h0, clr_reg} :
      hit_adrl ? {24'h0, adrl_reg} :
      hit_adrh ? {27'h0, adrh_reg} :
      hit_wrdl ? {24'h0, wrdl_reg} :
      hit_wrdh ? {24'h0, wrdh_reg} : 32'h0;

  // APB answer: one wait state, error on unmapped address
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~hit;
      prdata_reg  <= (setup & ~apb_i.pwrite) ? rd_val : 32'h0;
    end
  end

  // Sequencer state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start_prog) begin
          state_next = ST_PROG;
        end else if (start_read) begin
          state_next = ST_READ;
        end
      end
      ST_PROG: begin
        if (prog_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_READ: begin
        if (read_done) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // Busy counter; trigger stays high for the full count
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      stall_reg <= 1'b0;
      erase_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      stall_reg <= state_next != ST_IDLE;
      if (start_prog) begin
        cnt_reg   <= CW'(PROG_CYCLES - 1);
        erase_reg <= op_new == OP_ERASE;
      end else if (start_read) begin
        cnt_reg <= CW'(READ_CYC - 1);
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Control bits; software sets the triggers, hardware clears them on completion
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      opsel_reg    <= OPSEL_RST;
      rden_reg     <= 1'b0;
      rdtrig_reg   <= 1'b0;
      progtrig_reg <= 1'b0;
      unlocked_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        opsel_reg <= op_new;
        rden_reg  <= wd[BIT_RD_EN];
      end
      if (start_prog) begin
        progtrig_reg <= 1'b1;
      end else if (prog_done) begin
        progtrig_reg <= 1'b0;
      end
      if (start_read) begin
        rdtrig_reg <= 1'b1;
      end else if (read_done) begin
        rdtrig_reg <= 1'b0;
      end
      // Grant from unlock logic wins over a software relock
      if (unlock_grant_i) begin
        unlocked_reg <= 1'b1;
      end else if (wr_ctrl & ~wd[BIT_UNLOCKED]) begin
        unlocked_reg <= 1'b0;
      end
    end
  end

  // Address and data byte registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      adrl_reg <= 8'h00;
      adrh_reg <= 5'h00;
      wrdl_reg <= 8'h00;
      wrdh_reg <= 8'h00;
    end else begin
      if (wr_adrl) begin
        adrl_reg <= wd;
      end
      if (wr & hit_adrh) begin
        adrh_reg <= wd[4:0];
      end
      if (read_done) begin
        {wrdh_reg, wrdl_reg} <= flash_mem[full_addr];
      end else begin
        if (wr & hit_wrdl) begin
          wrdl_reg <= wd;
        end
        if (wr_wrdh) begin
          wrdh_reg <= wd;
        end
      end
    end
  end

  // Buffer clear request, self-clearing after one cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clr_reg <= 1'b0;
    end else if (wr & hit_clr & wd[BIT_CLEAR]) begin
      clr_reg <= 1'b1;
    end else begin
      clr_reg <= 1'b0;
    end
  end

  // Buffer index; saturates so extra words overwrite the last slot
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx_reg <= '0;
    end else if (clr_reg) begin
      idx_reg <= '0;
    end else if (wr_adrl) begin
      idx_reg <= wd[OFS_BITS-1:0];
    end else if (wr_wrdh && idx_reg != OFS_BITS'(BUF_WORDS - 1)) begin
      idx_reg <= idx_reg + 1'b1;
    end
  end

  // Page buffer; array has no reset, cleared by the clear bit
  always_ff @(posedge core_clk_i) begin
    if (clr_reg) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        buf_mem[i] <= ERASED_WORD;
      end
    end else if (wr_wrdh) begin
      buf_mem[idx_reg] <= {wd, wrdl_reg};
    end
  end

  // Flash array update at end of the busy time. Programming only sets
  // bits, so a failed page may be rewritten without an erase.
  always_ff @(posedge core_clk_i) begin
    if (prog_done) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        if (erase_reg) begin
          flash_mem[word_addr(page, i)] <= ERASED_WORD;
        end else begin
          flash_mem[word_addr(page, i)] <=
              flash_mem[word_addr(page, i)] | buf_mem[i];
        end
      end
    end
  end

  assign prdata_o    = prdata_reg;
  assign pready_o    = pready_reg;
  assign pslverr_o   = pslverr_reg;
  assign cpu_stall_o = stall_reg;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_idx_step;
    wr_wrdh && idx_reg < 5'd31 |=> idx_reg == $past(idx_reg) + 5'd1;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("index did not step");

  property p_idx_sat;
    wr_wrdh && idx_reg == 5'd31 |=> idx_reg == 5'd31;
  endproperty
  a_idx_sat: assert property (p_idx_sat) else $error("index left last word");

  property p_commit;
    wr_wrdh && !clr_reg |=> buf_mem[$past(idx_reg)] == {$past(wd), $past(wrdl_reg)};
  endproperty
  a_commit: assert property (p_commit) else $error("word not committed");

  property p_locked;
    wr_ctrl && wd[BIT_PROG] && !unlocked_reg |=> !progtrig_reg && !cpu_stall_o;
  endproperty
  a_locked: assert property (p_locked) else $error("locked flash started");

  property p_prog_stall;
    start_prog |=> (progtrig_reg && cpu_stall_o) [*8];
  endproperty
  a_prog_stall: assert property (p_prog_stall) else $error("stall dropped");

  property p_prog_end;
    prog_done |=> !progtrig_reg && !cpu_stall_o && state_reg == ST_IDLE;
  endproperty
  a_prog_end: assert property (p_prog_end) else $error("trigger not cleared");

  property p_erase_zero;
    prog_done && erase_reg |=> flash_mem[word_addr($past(page), 31)] == ERASED_WORD;
  endproperty
  a_erase_zero: assert property (p_erase_zero) else $error("page not erased");

  property p_read_time;
    start_read |=> rdtrig_reg ##[1:RD_WAIT] !rdtrig_reg;
  endproperty
  a_read_time: assert property (p_read_time) else $error("read too long");

  property p_read_unlocked;
    start_read && !unlocked_reg |=> rdtrig_reg && cpu_stall_o;
  endproperty
  a_read_unlocked: assert property (p_read_unlocked) else $error("read refused");

  property p_clear;
    clr_reg |=> idx_reg == '0 && buf_mem[0] == ERASED_WORD && !clr_reg;
  endproperty
  a_clear: assert property (p_clear) else $error("buffer not cleared");

  property p_addr_idx;
    wr_adrl |=> idx_reg == $past(wd[4:0]);
  endproperty
  a_addr_idx: assert property (p_addr_idx) else $error("index not loaded");

  c_erase: cover property (start_prog && op_new == OP_ERASE);
  c_write: cover property (prog_done && !erase_reg);
  c_read:  cover property (read_done);
  c_sat:   cover property (wr_wrdh && idx_reg == 5'd31);

endmodule

// [verification/flash_iap_page_programmer_tb_top.sv]
// Purpose: Self-checking bench for the flash page programmer over APB
// Assumes: One wait state or more per access; short program time in sim
// Notes:   Flash words are checked through the read operation only
`timescale 1ns/100ps
module flash_iap_page_programmer_tb_top;
  import iap_pkg::*;
  localparam int PC    = 20;
  localparam int LIMIT = 4000;
  logic        core_clk_i;
  logic        rst_i;
  apb_req_t    req;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        unlock_grant_i;
  logic        cpu_stall_o;
  logic        last_err;
  logic [31:0] q;
  int          bad_count;
  int          tests_run;
  int          cyc;

  flash_iap_page_programmer #(.PROG_CYCLES(PC)) u_flash_iap_page_programmer (
    .core_clk_i     (core_clk_i),
    .rst_i          (rst_i),
    .apb_i          (req),
    .prdata_o       (prdata_o),
    .pready_o       (pready_o),
    .pslverr_o      (pslverr_o),
    .unlock_grant_i (unlock_grant_i),
    .cpu_stall_o    (cpu_stall_o)
  );

  // Clock at 40 MHz, the fastest rate while programming
  initial core_clk_i = 1'b0;
  always #12.5 core_clk_i = ~core_clk_i;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge core_clk_i);
    req.penable <= 1'b1;
    @(posedge core_clk_i);
    while (pready_o !== 1'b1) begin
      @(posedge core_clk_i);
    end
    q        = prdata_o;
    last_err = pslverr_o;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, q, exp);
  endtask

  task automatic set_addr(input logic [12:0] fa);
    wr(OFF_ADRH, {27'h0, fa[12:8]});
    wr(OFF_ADRL, {24'h0, fa[7:0]});
  endtask

  // Low byte first, high byte commits the word
  task automatic load_word(input logic [15:0] w);
    wr(OFF_WRDL, {24'h0, w[7:0]});
    wr(OFF_WRDH, {24'h0, w[15:8]});
  endtask

  // Start an operation and count how long the CPU is held
  task automatic op(input logic [7:0] ctrl, input int exp_cyc);
    int n;
    n = 0;
    wr(OFF_CTRL, {24'h0, ctrl});
    #1;
    while (cpu_stall_o === 1'b1 && n < 200) begin
      @(posedge core_clk_i);
      #1;
      n = n + 1;
    end
    chk("stall cycles", n, exp_cyc);
  endtask

  task automatic rd_flash(input logic [12:0] fa, input logic [15:0] exp, input logic ul);
    set_addr(fa);
    op({ul, 7'h33}, READ_CYC);
    rd_chk("ctrl after read", OFF_CTRL, {24'h0, ul, 7'h32});
    rd_chk("word low", OFF_WRDL, {24'h0, exp[7:0]});
    rd_chk("word high", OFF_WRDH, {24'h0, exp[15:8]});
  endtask

  // Main sequence
  initial begin
    req            = '0;
    rst_i          = 1'b1;
    unlock_grant_i = 1'b0;
    bad_count      = 0;
    tests_run      = 0;
    cyc            = 0;
    // Hang guard, counted as a mismatch
    fork
      begin
        while (cyc < LIMIT) begin
          @(posedge core_clk_i);
          cyc = cyc + 1;
        end
        bad_count = bad_count + 1;
        stop_test();
      end
    join_none
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl reset", OFF_CTRL, 32'h0);
    rd_chk("clear reset", OFF_CLEAR, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", {31'h0, last_err}, 32'h1);
    chk("unmapped data", q, 32'h0);
    // Locked: erase and write refused
    set_addr(13'h3e0);
    op(8'h14, 0);
    op(8'h04, 0);
    // Unlock pulse stands for the enable procedure
    @(posedge core_clk_i);
    unlock_grant_i <= 1'b1;
    @(posedge core_clk_i);
    unlock_grant_i <= 1'b0;
    rd_chk("unlocked", OFF_CTRL, 32'h80);
    op(8'ha4, 0);
    // Erase page, then blank check two words
    op(8'h94, PC);
    rd_chk("ctrl after erase", OFF_CTRL, 32'h90);
    rd_flash(13'h3e7, ERASED_WORD, 1'b1);
    rd_flash(13'h3ff, ERASED_WORD, 1'b1);
    // Clear buffer, load three words from index 30
    wr(OFF_CLEAR, 32'h1);
    rd_chk("clear done", OFF_CLEAR, 32'h0);
    set_addr(13'h3fe);
    load_word(16'ha55a);
    load_word(16'h0f0f);
    load_word(16'h3c30);
    op(8'h84, PC);
    rd_flash(13'h3fe, 16'ha55a, 1'b1);
    rd_flash(13'h3ff, 16'h3c30, 1'b1);
    rd_flash(13'h3e0, 16'h0000, 1'b1);
    // Rewrite same page without erase after a clear
    wr(OFF_CLEAR, 32'h1);
    set_addr(13'h3e5);
    load_word(16'h1234);
    op(8'h84, PC);
    rd_flash(13'h3e5, 16'h1234, 1'b1);
    rd_flash(13'h3ff, 16'h3c30, 1'b1);
    // Relock; erase refused, read still allowed
    wr(OFF_CTRL, 32'h0);
    rd_chk("relocked", OFF_CTRL, 32'h0);
    set_addr(13'h3fe);
    op(8'h94, 0);
    op(8'h31, 0);
    rd_flash(13'h3fe, 16'ha55a, 1'b0);
    stop_test();
  end
endmodule
